// File: sim/tape_option_core_bench.sv
// self-checking bench for the tape option core
`timescale 1ns/1ps
`define CHK(nm, exp, act) begin checked++; if ((act) !== (exp)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, act); end end
module tape_option_core_bench;
    localparam int NWIN = 20;
    localparam int LWIN = 60;
    localparam int BUFW = 16;
    logic clk, rst_n, hold, wide, hden, ssel, ign, lgap, inh, edge_sel, want, grant, yield, stb;
    logic loc, scv, nrz, brk, rec, cmd, fly, go, ok;
    logic core_rst_n, req, busy, wide_o, hd, nrz_w, nrz_mode, stop, fly_o, wstb, late, mbusy;
    logic [15:0] word, wn;
    logic [21:0] addr, addr_o;
    logic [7:0] mode, wdata, mid, fin_b, last_b;
    logic [3:0] gap;
    logic [16:0] rows [5];
    logic [15:0] exp_q [$];
    int failures = 0, checked = 0, late_n = 0, stop_n = 0, i, n;
    tape_option_core #(.WIN_NORMAL_CYC(NWIN), .WIN_LONG_CYC(LWIN), .BUF_WORDS(BUFW)) u_tape_option_core (
        .CLOCK_I(clk), .RESET_N_I(rst_n), .RUN_HOLD_SELECT_I(hold), .WIDE_ADDRESS_SELECT_I(wide),
        .HOST_DENSITY_SELECT_ENABLE_I(hden), .STREAMING_MODE_SELECT_I(ssel), .DENSITY_INDICATOR_IGNORE_I(ign),
        .LONG_GAP_SELECT_I(lgap), .FLY_COMMAND_INHIBIT_I(inh), .STROBE_EDGE_SELECT_I(edge_sel),
        .CORE_RESET_N_O(core_rst_n), .DMA_WANT_I(want), .DMA_GRANT_I(grant), .DMA_YIELD_I(yield),
        .DMA_WORD_STROBE_I(stb), .DMA_WORD_I(word), .DMA_ADDR_I(addr), .DMA_BUS_REQUEST_O(req),
        .DMA_BUS_BUSY_O(busy), .DMA_ADDR_O(addr_o), .WIDE_ADDRESS_O(wide_o), .LOCAL_HIGH_DENSITY_I(loc),
        .SET_CHAR_VALID_I(scv), .SET_CHAR_MODE_I(mode), .HIGH_DENSITY_O(hd), .NRZ_DENSITY_INDICATOR_I(nrz_w),
        .NRZ_MODE_O(nrz_mode), .RECORD_DONE_I(rec), .CMD_ISSUE_I(cmd), .GAP_TENTHS_O(gap), .STREAM_STOP_O(stop),
        .FLY_CMD_REQ_I(fly), .FLY_CMD_O(fly_o), .WRITE_STROBE_I(wstb), .WRITE_DATA_O(wdata),
        .WRITE_DATA_LATE_O(late));
    tape_transport_model u_tape_transport_model (.clk_i(clk), .go_i(go), .nrz_i(nrz), .ignore_i(ign), .brk_i(brk),
        .data_i(wdata), .strobe_o(wstb), .nrz_o(nrz_w), .busy_o(mbusy), .mid_o(mid), .end_o(fin_b));
    // ----
    // clock, pulse counters, helpers
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (late === 1'b1) late_n <= late_n + 1;
        if (stop === 1'b1) stop_n <= stop_n + 1;
    end
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic strobe;
        int j;
        @(negedge clk);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (j = 0; j < 40; j++) begin
            @(posedge clk);
            if (mbusy === 1'b0) break;
        end
        // a transport that never finishes is a failure, not a silent pass
        if (j == 40) failures++;
        // hand back on a falling edge so callers never drive on the sampling edge
        @(negedge clk);
    endtask
    task automatic pull(input int nw);
        logic [15:0] w;
        logic [7:0] e;
        int j, b;
        for (j = 0; j < nw; j++) begin
            w = exp_q.pop_front();
            for (b = 0; b < 2; b++) begin
                e = b ? w[15:8] : w[7:0];
                strobe();
                `CHK("mid byte", edge_sel ? e : last_b, mid)
                `CHK("byte", e, fin_b)
                last_b = e;
            end
        end
    endtask
    // two words per grant, optionally ended by a waiting competitor
    task automatic burst(input logic y, output logic okv);
        int j;
        okv = 1'b0;
        @(negedge clk);
        want = 1'b1;
        for (j = 0; j < 8 && !okv; j++) begin
            @(negedge clk);
            okv = (req === 1'b1);
        end
        if (okv) begin
            grant = 1'b1;
            @(negedge clk);
            grant = 1'b0;
            `CHK("busy", 1'b1, busy)
            for (j = 0; j < 2; j++) begin
                stb = 1'b1;
                word = wn;
                wn = wn + 16'h0103;
                want = y;
                yield = y;
                exp_q.push_back(word);
                @(negedge clk);
            end
            stb = 1'b0;
        end
        want = 1'b0;
        yield = 1'b0;
        tick(2);
    endtask
    task automatic win(input logic lg, input int w);
        int j;
        lgap = lg;
        tick(4);
        rec = 1'b1;
        @(negedge clk);
        rec = 1'b0;
        for (j = 0; j < 200; j++) begin
            @(posedge clk);
            #1;
            if (stop === 1'b1) break;
        end
        `CHK("window", 1'b1, j >= w - 1 && j <= w + 2)
        `CHK("gap", lg ? 4'hC : 4'h6, gap)
        tick(1);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----
    // watchdog and main sequence
    // ----
    initial begin
        #200000;
        failures++;
        summarize();
    end
    initial begin
        {hold, wide, hden, ssel, ign, lgap, inh, edge_sel, want, grant, yield, stb} = '0;
        {loc, scv, nrz, brk, rec, cmd, fly, go} = '0;
        word = 16'h0000;
        addr = 22'h3ABCDE;
        mode = 8'h00;
        rst_n = 1'b0;
        last_b = 8'h00;
        wn = 16'hA55A;
        // {ssel,wide,ign,nrz,brk,lgap,inh,fly,loc} then {gap,nrz_mode,fly_o,wide_o,hd}
        rows = '{17'h0236D, 17'h0FEC2, 17'h00EC0, 17'h0E163, 17'h10A64};
        tick(5);
        rst_n = 1'b1;
        tick(3);
        `CHK("core run", 1'b1, core_rst_n)
        `CHK("reset gap", 4'h6, gap)
        `CHK("reset dens", 1'b0, hd)
        `CHK("reset req", 1'b0, req)
        fin("reset");
        for (i = 0; i < 5; i++) begin
            {ssel, wide, ign, nrz, brk, lgap, inh, fly, loc} = rows[i][16:8];
            tick(6);
            `CHK("gap", rows[i][7:4], gap)
            `CHK("nrz", rows[i][3], nrz_mode)
            `CHK("fly", rows[i][2], fly_o)
            `CHK("wide", rows[i][1], wide_o)
            `CHK("dens", rows[i][0], hd)
        end
        {ssel, wide, ign, nrz, brk, lgap, inh, fly} = '0;
        hden = 1'b1;
        tick(4);
        for (i = 0; i < 2; i++) begin
            mode = i ? 8'hFE : 8'h01;
            scv = 1'b1;
            @(negedge clk);
            scv = 1'b0;
            tick(2);
            `CHK("host dens", i == 0, hd)
        end
        {hden, loc} = '0;
        fin("options");
        hold = 1'b1;
        fly = 1'b1;
        tick(5);
        `CHK("held", 1'b0, core_rst_n)
        `CHK("held fly", 1'b0, fly_o)
        hold = 1'b0;
        tick(5);
        `CHK("released", 1'b1, core_rst_n)
        `CHK("fly", 1'b1, fly_o)
        fly = 1'b0;
        fin("hold");
        win(1'b0, NWIN);
        win(1'b1, LWIN);
        rec = 1'b1;
        @(negedge clk);
        rec = 1'b0;
        tick(5);
        cmd = 1'b1;
        @(negedge clk);
        cmd = 1'b0;
        n = stop_n;
        tick(80);
        `CHK("cancel", n, stop_n)
        lgap = 1'b0;
        fin("stream");
        burst(1'b1, ok);
        `CHK("req", 1'b1, ok)
        `CHK("addr", 22'h02BCDE, addr_o)
        pull(2);
        n = late_n;
        strobe();
        `CHK("late", n + 1, late_n)
        `CHK("held byte", last_b, fin_b)
        edge_sel = 1'b1;
        tick(4);
        burst(1'b0, ok);
        `CHK("req", 1'b1, ok)
        pull(2);
        edge_sel = 1'b0;
        tick(4);
        fin("dma");
        ok = 1'b1;
        for (i = 0; i < 40 && ok; i++) burst(1'b0, ok);
        `CHK("full", 1'b1, !ok && exp_q.size() >= BUFW)
        pull(exp_q.size());
        wide = 1'b1;
        tick(4);
        burst(1'b0, ok);
        `CHK("req", 1'b1, ok)
        `CHK("wide addr", 22'h3ABCDE, addr_o)
        pull(2);
        fin("fill");
        summarize();
    end
endmodule

// File: sim/tape_option_core_properties.sv
// port-level assertions for the tape option core
`timescale 1ns/1ps
module tape_option_core_properties (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    // options
    input wire logic RUN_HOLD_SELECT_I,
    input wire logic STREAMING_MODE_SELECT_I,
    input wire logic DENSITY_INDICATOR_IGNORE_I,
    input wire logic LONG_GAP_SELECT_I,
    input wire logic FLY_COMMAND_INHIBIT_I,
    // watched traffic
    input wire logic CORE_RESET_N_O,
    input wire logic DMA_WORD_STROBE_I,
    input wire logic DMA_BUS_BUSY_O,
    input wire logic [21:0] DMA_ADDR_O,
    input wire logic WIDE_ADDRESS_O,
    input wire logic NRZ_DENSITY_INDICATOR_I,
    input wire logic NRZ_MODE_O,
    input wire logic RECORD_DONE_I,
    input wire logic CMD_ISSUE_I,
    input wire logic [3:0] GAP_TENTHS_O,
    input wire logic STREAM_STOP_O,
    input wire logic FLY_CMD_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);
    // ----
    // words per grant, saturating at three
    // ----
    logic [1:0] words_q;
    logic [1:0] words_d;
    always_comb begin
        words_d = DMA_BUS_BUSY_O ? words_q + {1'b0, DMA_WORD_STROBE_I && words_q != 2'h3} : 2'h0;
    end
    always_ff @(posedge CLOCK_I) begin
        words_q <= RESET_N_I ? words_d : 2'h0;
    end
    // ----
    // properties
    // ----
    property p_hold; RUN_HOLD_SELECT_I [*4] |-> !CORE_RESET_N_O; endproperty
    a_hold: assert property (p_hold) else $error("core runs while hold option on");
    property p_addr; !WIDE_ADDRESS_O [*2] |-> DMA_ADDR_O[21:18] == 4'h0; endproperty
    a_addr: assert property (p_addr) else $error("upper address bits driven in narrow mode");
    property p_fly; FLY_COMMAND_INHIBIT_I [*3] |-> !FLY_CMD_O; endproperty
    a_fly: assert property (p_fly) else $error("fly command while inhibited");
    property p_gap_long; (LONG_GAP_SELECT_I && !STREAMING_MODE_SELECT_I) [*3] |-> GAP_TENTHS_O == 4'hC; endproperty
    a_gap_long: assert property (p_gap_long) else $error("long gap not selected");
    property p_gap_norm; !LONG_GAP_SELECT_I [*3] |-> GAP_TENTHS_O == 4'h6; endproperty
    a_gap_norm: assert property (p_gap_norm) else $error("normal gap not selected");
    property p_ign; DENSITY_INDICATOR_IGNORE_I [*4] |-> !NRZ_MODE_O; endproperty
    a_ign: assert property (p_ign) else $error("indicator honoured while ignored");
    property p_nrz;
        (!DENSITY_INDICATOR_IGNORE_I && NRZ_DENSITY_INDICATOR_I && !RUN_HOLD_SELECT_I) [*5] |-> NRZ_MODE_O;
    endproperty
    a_nrz: assert property (p_nrz) else $error("indicator not taken as nrz mode");
    property p_stop;
        RECORD_DONE_I && !STREAMING_MODE_SELECT_I ##1 (!CMD_ISSUE_I && !RECORD_DONE_I) [*8] |-> !STREAM_STOP_O;
    endproperty
    a_stop: assert property (p_stop) else $error("stream stop before window end");
    property p_grant; $fell(DMA_BUS_BUSY_O) && CORE_RESET_N_O |-> words_q[1]; endproperty
    a_grant: assert property (p_grant) else $error("bus released after fewer than two words");
endmodule
bind tape_option_core tape_option_core_properties u_tape_option_core_properties (.CLOCK_I(CLOCK_I),
    .RESET_N_I(RESET_N_I), .RUN_HOLD_SELECT_I(RUN_HOLD_SELECT_I), .STREAMING_MODE_SELECT_I(STREAMING_MODE_SELECT_I),
    .DENSITY_INDICATOR_IGNORE_I(DENSITY_INDICATOR_IGNORE_I), .LONG_GAP_SELECT_I(LONG_GAP_SELECT_I),
    .FLY_COMMAND_INHIBIT_I(FLY_COMMAND_INHIBIT_I), .CORE_RESET_N_O(CORE_RESET_N_O),
    .DMA_WORD_STROBE_I(DMA_WORD_STROBE_I), .DMA_BUS_BUSY_O(DMA_BUS_BUSY_O), .DMA_ADDR_O(DMA_ADDR_O),
    .WIDE_ADDRESS_O(WIDE_ADDRESS_O), .NRZ_DENSITY_INDICATOR_I(NRZ_DENSITY_INDICATOR_I), .NRZ_MODE_O(NRZ_MODE_O),
    .RECORD_DONE_I(RECORD_DONE_I), .CMD_ISSUE_I(CMD_ISSUE_I), .GAP_TENTHS_O(GAP_TENTHS_O),
    .STREAM_STOP_O(STREAM_STOP_O), .FLY_CMD_O(FLY_CMD_O));

// File: sim/tape_transport_model.sv
// transport-side model: write strobe source and density indicator
`timescale 1ns/1ps
module tape_transport_model (
    // from the bench, and write data from the coupler
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic nrz_i,
    input wire logic ignore_i,
    input wire logic brk_i,
    input wire logic [7:0] data_i,
    // transport pins and observations
    output logic strobe_o,
    output logic nrz_o,
    output logic busy_o,
    output logic [7:0] mid_o,
    output logic [7:0] end_o
);
    // ----
    // indicator and strobe
    // ----
    // indicator kept low when the coupler ignores it, unless told to misbehave
    assign nrz_o = nrz_i && (!ignore_i || brk_i);
    initial begin
        strobe_o = 1'b0;
        busy_o = 1'b0;
        mid_o = 8'h00;
        end_o = 8'h00;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                @(negedge clk_i);
                busy_o = 1'b1;
                strobe_o = 1'b1;
                repeat (4) @(negedge clk_i);
                mid_o = data_i;
                strobe_o = 1'b0;
                repeat (4) @(negedge clk_i);
                end_o = data_i;
                busy_o = 1'b0;
            end
        end
    end
endmodule

// File: src/tape_option_consts.svh
// option bit positions, figures and timing counts for the tape option logic
// ----------------------------------------
// Behaviour
// ----------------------------------------
// Behaviour
// - While the run/hold option is on, the coupler except its option synchronisers is held in reset, and it runs normally when it is off.
// - With the wide address option on, transfers drive 22-bit bus addresses, otherwise only 18-bit ones.
// - With host density selection on, bit 00 of the host's characteristic mode byte picks high or low density.
// - With the indicator-ignore option off, an asserted NRZ indicator means 800 bpi and check characters.
// - With the indicator-ignore option on, the NRZ indicator is disregarded and PE or GCR is assumed.
// - In streaming mode gaps are 0.6 inch normally and 1.2 inches with the long gap option on.
// - With the fly inhibit option on, no on-the-fly command reaches the transport.
// - Write bytes are presented after the trailing strobe edge, or after the leading edge with the option on.
// - A data buffer of up to 3.5K bytes sits between the DMA side and the tape side.
// - Each bus grant carries at least two words before the bus is given up.
`ifndef TAPE_OPTION_CONSTS_SVH
`define TAPE_OPTION_CONSTS_SVH

// ----------------------------------------
// option vector bit positions
// ----------------------------------------
`define OPT_COUNT 8
`define OPT_RUN_HOLD 0
`define OPT_WIDE_ADDR 1
`define OPT_HOST_DENS 2
`define OPT_STREAM_SEL 3
`define OPT_IND_IGNORE 4
`define OPT_LONG_GAP 5
`define OPT_FLY_INHIBIT 6
`define OPT_STROBE_EDGE 7
`define OPT_RESET_VAL 8'h00

// ----------------------------------------
// addressing and density
// ----------------------------------------
`define ADDR_WIDE_BITS 22
`define ADDR_NARROW_MASK 22'h03FFFF
`define ADDR_WIDE_MASK 22'h3FFFFF
`define DENS_MODE_BIT 0

// ----------------------------------------
// gaps, buffer, bus grant
// ----------------------------------------
`define GAP_NORMAL_TENTHS 4'h6
`define GAP_LONG_TENTHS 4'hC
`define BUF_BYTES 3584
`define FIFO_WORDS 8
`define MIN_WORDS_PER_GRANT 2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10.0
`define WIN_NORMAL_MS 2.5
`define WIN_LONG_MS 8.5
`define WIN_NORMAL_CYC $rtoi(`WIN_NORMAL_MS * 1.0E6 / `CLK_PERIOD_NS)
`define WIN_LONG_CYC $rtoi(`WIN_LONG_MS * 1.0E6 / `CLK_PERIOD_NS)

`endif

// File: src/tape_option_core.sv
// option configuration, data buffer and write strobe logic of the tape coupler
`timescale 1ns/1ps
`include "tape_option_consts.svh"
module tape_option_core
    import tape_option_pkg::*;
#(
    parameter int WIN_NORMAL_CYC = `WIN_NORMAL_CYC,
    parameter int WIN_LONG_CYC = `WIN_LONG_CYC,
    parameter int BUF_WORDS = `BUF_BYTES / 2,
    parameter int FIFO_DEPTH = `FIFO_WORDS,
    parameter int MIN_WORDS = `MIN_WORDS_PER_GRANT
) (
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    // option switches
    input wire logic RUN_HOLD_SELECT_I,
    input wire logic WIDE_ADDRESS_SELECT_I,
    input wire logic HOST_DENSITY_SELECT_ENABLE_I,
    input wire logic STREAMING_MODE_SELECT_I,
    input wire logic DENSITY_INDICATOR_IGNORE_I,
    input wire logic LONG_GAP_SELECT_I,
    input wire logic FLY_COMMAND_INHIBIT_I,
    input wire logic STROBE_EDGE_SELECT_I,
    // core status
    output logic CORE_RESET_N_O,
    // dma side
    input wire logic DMA_WANT_I,
    input wire logic DMA_GRANT_I,
    input wire logic DMA_YIELD_I,
    input wire logic DMA_WORD_STROBE_I,
    input wire logic [15:0] DMA_WORD_I,
    input wire logic [21:0] DMA_ADDR_I,
    output logic DMA_BUS_REQUEST_O,
    output logic DMA_BUS_BUSY_O,
    output logic [21:0] DMA_ADDR_O,
    output logic WIDE_ADDRESS_O,
    // density
    input wire logic LOCAL_HIGH_DENSITY_I,
    input wire logic SET_CHAR_VALID_I,
    input wire logic [7:0] SET_CHAR_MODE_I,
    output logic HIGH_DENSITY_O,
    input wire logic NRZ_DENSITY_INDICATOR_I,
    output logic NRZ_MODE_O,
    // streaming
    input wire logic RECORD_DONE_I,
    input wire logic CMD_ISSUE_I,
    output logic [3:0] GAP_TENTHS_O,
    output logic STREAM_STOP_O,
    // commands to transport
    input wire logic FLY_CMD_REQ_I,
    output logic FLY_CMD_O,
    // tape write data
    input wire logic WRITE_STROBE_I,
    output logic [7:0] WRITE_DATA_O,
    output logic WRITE_DATA_LATE_O
);
    localparam int BW = $clog2(BUF_WORDS);
    localparam int TW = $clog2(WIN_LONG_CYC + 1);

    // ----------------------------------------
    // option synchronisers
    // ----------------------------------------
    logic [`OPT_COUNT-1:0] opt_raw, opt_meta_q, opt_q;
    logic core_rst_n;

    assign opt_raw = {STROBE_EDGE_SELECT_I, FLY_COMMAND_INHIBIT_I, LONG_GAP_SELECT_I,
                      DENSITY_INDICATOR_IGNORE_I, STREAMING_MODE_SELECT_I,
                      HOST_DENSITY_SELECT_ENABLE_I, WIDE_ADDRESS_SELECT_I, RUN_HOLD_SELECT_I};

    // plain reset only, so the hold switch can release the core it holds
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            opt_meta_q <= `OPT_RESET_VAL;
            opt_q <= `OPT_RESET_VAL;
        end else begin
            opt_meta_q <= opt_raw;
            opt_q <= opt_meta_q;
        end
    end

    assign core_rst_n = RESET_N_I & ~opt_q[`OPT_RUN_HOLD];
    assign CORE_RESET_N_O = core_rst_n;

    // ----------------------------------------
    // combinational option effects
    // ----------------------------------------
    logic streaming, long_gap;
    assign streaming = ~opt_q[`OPT_STREAM_SEL];
    assign long_gap = streaming & opt_q[`OPT_LONG_GAP];
    assign GAP_TENTHS_O = long_gap ? `GAP_LONG_TENTHS : `GAP_NORMAL_TENTHS;
    assign FLY_CMD_O = FLY_CMD_REQ_I & ~opt_q[`OPT_FLY_INHIBIT] & core_rst_n;
    assign WIDE_ADDRESS_O = opt_q[`OPT_WIDE_ADDR];

    // ----------------------------------------
    // dma grant, word buffer
    // ----------------------------------------
    dma_state_t st_q, st_d;
    logic [1:0] words_q, words_d;
    logic [BW-1:0] bwr_q, bwr_d, brd_q, brd_d;
    logic [BW:0] bcnt_q, bcnt_d;
    logic [15:0] buf_mem [BUF_WORDS];
    logic buf_wr, buf_rd, room1, room2;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [15:0] fifo_out_data;

    function automatic logic [BW-1:0] buf_next(input logic [BW-1:0] p);
        buf_next = (p == BW'(BUF_WORDS - 1)) ? '0 : p + 1'b1;
    endfunction

    assign room1 = (bcnt_q < (BW + 1)'(BUF_WORDS));
    assign room2 = (bcnt_q <= (BW + 1)'(BUF_WORDS - MIN_WORDS));
    assign buf_wr = (st_q == DMA_XFER) & DMA_WORD_STROBE_I & room1;
    assign buf_rd = (bcnt_q != '0) & fifo_in_ready;
    assign DMA_BUS_REQUEST_O = (st_q == DMA_REQ);
    assign DMA_BUS_BUSY_O = (st_q == DMA_XFER);

    always_comb begin
        st_d = st_q;
        words_d = words_q;
        case (st_q)
            DMA_IDLE: begin
                if (DMA_WANT_I && room2) begin
                    st_d = DMA_REQ;
                end
            end
            DMA_REQ: begin
                if (DMA_GRANT_I) begin
                    st_d = DMA_XFER;
                    words_d = '0;
                end
            end
            DMA_XFER: begin
                if (buf_wr && words_q != 2'h3) begin
                    words_d = words_q + 1'b1;
                end
                // yield only once the minimum burst is in
                if (words_d >= 2'(MIN_WORDS) && (DMA_YIELD_I || !DMA_WANT_I || !room2)) begin
                    st_d = DMA_IDLE;
                end
            end
            default: begin
                st_d = DMA_IDLE;
            end
        endcase
        bwr_d = buf_wr ? buf_next(bwr_q) : bwr_q;
        brd_d = buf_rd ? buf_next(brd_q) : brd_q;
        bcnt_d = bcnt_q;
        if (buf_wr && !buf_rd) begin
            bcnt_d = bcnt_q + 1'b1;
        end else if (buf_rd && !buf_wr) begin
            bcnt_d = bcnt_q - 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!core_rst_n) begin
            st_q <= DMA_IDLE;
            words_q <= '0;
            bwr_q <= '0;
            brd_q <= '0;
            bcnt_q <= '0;
        end else begin
            st_q <= st_d;
            words_q <= words_d;
            bwr_q <= bwr_d;
            brd_q <= brd_d;
            bcnt_q <= bcnt_d;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (buf_wr) begin
            buf_mem[bwr_q] <= DMA_WORD_I;
        end
    end

    word_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLOCK_I),
        .rst_n_i(core_rst_n),
        .in_valid_i(bcnt_q != '0),
        .in_ready_o(fifo_in_ready),
        .in_data_i(buf_mem[brd_q]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ----------------------------------------
    // registered status: address, density, nrz
    // ----------------------------------------
    logic [21:0] addr_q, addr_d;
    logic dens_q, dens_d, nrz_q, nrz_d;

    always_comb begin
        addr_d = DMA_ADDR_I & (opt_q[`OPT_WIDE_ADDR] ? `ADDR_WIDE_MASK : `ADDR_NARROW_MASK);
        dens_d = dens_q;
        if (opt_q[`OPT_HOST_DENS]) begin
            if (SET_CHAR_VALID_I) begin
                dens_d = SET_CHAR_MODE_I[`DENS_MODE_BIT];
            end
        end else begin
            dens_d = LOCAL_HIGH_DENSITY_I;
        end
        // ignoring the indicator relies on every transport being PE or GCR
        nrz_d = NRZ_DENSITY_INDICATOR_I & ~opt_q[`OPT_IND_IGNORE];
    end

    always_ff @(posedge CLOCK_I) begin
        if (!core_rst_n) begin
            addr_q <= '0;
            dens_q <= 1'b0;
            nrz_q <= 1'b0;
        end else begin
            addr_q <= addr_d;
            dens_q <= dens_d;
            nrz_q <= nrz_d;
        end
    end

    assign DMA_ADDR_O = addr_q;
    assign HIGH_DENSITY_O = dens_q;
    assign NRZ_MODE_O = nrz_q;

    // ----------------------------------------
    // streaming command window
    // ----------------------------------------
    logic win_q, win_d, stop_q, stop_d;
    logic [TW-1:0] wcnt_q, wcnt_d, wlim;

    // a missed window makes the transport stop and reposition
    assign wlim = long_gap ? TW'(WIN_LONG_CYC - 1) : TW'(WIN_NORMAL_CYC - 1);

    always_comb begin
        win_d = win_q;
        wcnt_d = wcnt_q;
        stop_d = 1'b0;
        if (win_q) begin
            wcnt_d = wcnt_q + 1'b1;
            if (CMD_ISSUE_I) begin
                win_d = 1'b0;
            end else if (wcnt_q >= wlim) begin
                win_d = 1'b0;
                stop_d = 1'b1;
            end
        end
        if (RECORD_DONE_I && streaming) begin
            win_d = 1'b1;
            wcnt_d = '0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!core_rst_n) begin
            win_q <= 1'b0;
            wcnt_q <= '0;
            stop_q <= 1'b0;
        end else begin
            win_q <= win_d;
            wcnt_q <= wcnt_d;
            stop_q <= stop_d;
        end
    end

    assign STREAM_STOP_O = stop_q;

    // ----------------------------------------
    // write strobe, byte presentation
    // ----------------------------------------
    logic strb_q, half_q, half_d, late_q, late_d, edge_hit;
    logic [7:0] wdat_q, wdat_d;

    // strobe is active high; leading edge rises, trailing edge falls
    assign edge_hit = opt_q[`OPT_STROBE_EDGE] ? (WRITE_STROBE_I & ~strb_q) : (~WRITE_STROBE_I & strb_q);
    assign fifo_out_ready = edge_hit & half_q;

    always_comb begin
        wdat_d = wdat_q;
        half_d = half_q;
        late_d = 1'b0;
        if (edge_hit) begin
            if (fifo_out_valid) begin
                wdat_d = half_q ? fifo_out_data[15:8] : fifo_out_data[7:0];
                half_d = ~half_q;
            end else begin
                late_d = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!core_rst_n) begin
            strb_q <= 1'b0;
            half_q <= 1'b0;
            late_q <= 1'b0;
            wdat_q <= 8'h00;
        end else begin
            strb_q <= WRITE_STROBE_I;
            half_q <= half_d;
            late_q <= late_d;
            wdat_q <= wdat_d;
        end
    end

    assign WRITE_DATA_O = wdat_q;
    assign WRITE_DATA_LATE_O = late_q;
endmodule

// File: src/tape_option_pkg.sv
// types shared by the tape option logic
package tape_option_pkg;
    typedef enum logic [1:0] {
        DMA_IDLE,
        DMA_REQ,
        DMA_XFER
    } dma_state_t;
endpackage

// File: src/word_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_o = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem[rd_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        wr_d = push ? bump(wr_q) : wr_q;
        rd_d = pop ? bump(rd_q) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end
endmodule
